// file: acq_ctrl.sv
/*
 * Acquisition start, reference synchronisation and record capture toward
 * the DRAM FIFO write port, with two channel paths.
 * Assumes trigger, alignment strobe and reference arrive asynchronously on
 * pins, and that the DRAM FIFO accepts a beat whenever dram_ready_i is high.
 */
// Behaviour
// - Acquisition starts only on a trigger event
// - Phase lock enabled: triggers blocked until synced
// - After sync, first trigger starts acquisition
// - One full-rate record per time-slot trigger
// - Records written to DRAM FIFO at full rate
// - Record length up to 200 ms
// - Each I or Q sample is two bytes
// - Each down-converter bypasses independently
// - Retune centre and bandwidth immediately at run time
// - Stream indefinitely, records and continuous data
// - Per-channel output rate set independently
// - Record header: trigger time stamp, sequence number
// - Reference edge after strobe: lock NCOs, clear time
// - Decimation factor is a per-converter power of two
`include "acq_regs.svh"

module acq_ctrl
    import acq_pkg::*;
#(
    parameter int MAX_RECORD_CYCLES = `ACQ_MAX_REC_CYCLES,
    parameter int LEN_W = 24
)
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Asynchronous pins
    input wire logic trigger_i,
    input wire logic align_strobe_i,
    input wire logic ref_clk_i,
    // Acquisition control
    input wire logic arm_i,
    input wire logic continuous_i,
    input wire logic lock_enable_i,
    input wire logic [LEN_W-1:0] record_len_i,
    // Channel configuration
    input wire logic [`ACQ_LANES-1:0] bypass_i,
    input wire logic [`ACQ_LANES*`ACQ_DEC_LOG_W-1:0] dec_log2_i,
    input wire tune_type [`ACQ_LANES-1:0] tune_i,
    input wire logic [`ACQ_LANES-1:0] tune_load_i,
    // Samples
    input wire logic [`ACQ_LANES*`ACQ_SAMPLE_W-1:0] raw_i,
    input wire logic [`ACQ_LANES-1:0] raw_valid_i,
    input wire logic [`ACQ_LANES*`ACQ_SAMPLE_W-1:0] ddc_i,
    input wire logic [`ACQ_LANES-1:0] ddc_valid_i,
    // DRAM FIFO write port
    input wire logic dram_ready_i,
    output logic out_valid_o,
    output stream_beat_type out_beat_o,
    // Status and NCO control
    output logic sync_done_o,
    output logic acquiring_o,
    output logic overflow_o,
    output logic nco_lock_o,
    output tune_type [`ACQ_LANES-1:0] tune_o
);

    // -----------------------------------------------------------------------
    // Elaboration checks
    // -----------------------------------------------------------------------
    if (MAX_RECORD_CYCLES < 1 || MAX_RECORD_CYCLES >= (2 ** LEN_W))
    begin : g_bad_len
        $error("MAX_RECORD_CYCLES does not fit LEN_W");
    end

    localparam logic [LEN_W-1:0] MAX_LEN = LEN_W'(MAX_RECORD_CYCLES);

    function automatic logic rise(input logic prev, input logic cur);
        rise = cur && !prev;
    endfunction

    logic [1:0] rst_sync;
    logic rst_n;
    logic [1:0] trig_s, strobe_s, ref_s;
    logic trig_d, strobe_d, ref_d;
    logic trig_ev, strobe_ev, ref_ev;
    acq_state_type state;
    logic strobe_seen;
    logic [`ACQ_TS_W-1:0] timestamp;
    logic [`ACQ_TS_W-1:0] trig_time;
    logic [`ACQ_SEQ_W-1:0] seq;
    logic [1:0] hdr_left;
    logic [LEN_W-1:0] rec_left;
    logic [LEN_W-1:0] len_eff;
    logic [`ACQ_LANES*`ACQ_SAMPLE_W-1:0] lane_data;
    logic [`ACQ_LANES-1:0] lane_valid;
    logic start;

    // -----------------------------------------------------------------------
    // Reset release and pin synchronisers
    // -----------------------------------------------------------------------
    // Reset asserts at once and releases after two edges
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Two flops per pin, then one delay flop for edge detection
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_s <= 2'h0;
            strobe_s <= 2'h0;
            ref_s <= 2'h0;
            trig_d <= 1'b0;
            strobe_d <= 1'b0;
            ref_d <= 1'b0;
        end
        else
        begin
            trig_s <= {trig_s[0], trigger_i};
            strobe_s <= {strobe_s[0], align_strobe_i};
            ref_s <= {ref_s[0], ref_clk_i};
            trig_d <= trig_s[1];
            strobe_d <= strobe_s[1];
            ref_d <= ref_s[1];
        end
    end

    assign trig_ev = rise(trig_d, trig_s[1]);
    assign strobe_ev = rise(strobe_d, strobe_s[1]);
    assign ref_ev = rise(ref_d, ref_s[1]);

    // Trigger only counts while armed; anything earlier is simply lost
    assign start = (state == st_armed) && arm_i && trig_ev;

    // Requested length clamped to the longest record, zero taken as one
    assign len_eff = (record_len_i > MAX_LEN) ? MAX_LEN :
                     (record_len_i == '0) ? LEN_W'(1) : record_len_i;

    // -----------------------------------------------------------------------
    // Control state machine
    // -----------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            state <= st_idle;
        else
        begin
            unique case (state)
                st_idle:
                    if (arm_i)
                        state <= lock_enable_i ? st_sync_wait : st_armed;
                st_sync_wait:
                    if (!arm_i)
                        state <= st_idle;
                    else if (strobe_seen && ref_ev)
                        state <= st_armed;
                st_armed:
                    if (!arm_i)
                        state <= st_idle;
                    else if (start)
                        state <= continuous_i ? st_stream : st_record;
                st_record:
                    if (!arm_i)
                        state <= st_idle;
                    else if (hdr_left == 2'h0 && rec_left == LEN_W'(1))
                        state <= st_armed;
                st_stream:
                    if (!arm_i)
                        state <= st_idle;
            endcase
        end
    end

    // Alignment strobe remembered until the next reference edge
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            strobe_seen <= 1'b0;
        else if (state != st_sync_wait)
            strobe_seen <= 1'b0;
        else if (strobe_ev)
            strobe_seen <= 1'b1;
    end

    // Lock pulse and sync status
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nco_lock_o <= 1'b0;
            sync_done_o <= 1'b0;
        end
        else
        begin
            nco_lock_o <= (state == st_sync_wait) && arm_i && strobe_seen && ref_ev;
            if (state == st_idle && arm_i)
                sync_done_o <= !lock_enable_i;
            else if (state == st_sync_wait && arm_i && strobe_seen && ref_ev)
                sync_done_o <= 1'b1;
        end
    end

    // Time stamp counter cleared on the locking reference edge
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            timestamp <= '0;
        else if (state == st_sync_wait && arm_i && strobe_seen && ref_ev)
            timestamp <= '0;
        else
            timestamp <= timestamp + `ACQ_TS_W'(1);
    end

    // -----------------------------------------------------------------------
    // Record bookkeeping
    // -----------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_time <= '0;
            seq <= '0;
            hdr_left <= 2'h0;
            rec_left <= '0;
        end
        else if (state == st_idle)
        begin
            seq <= '0;
            hdr_left <= 2'h0;
        end
        else if (start && !continuous_i)
        begin
            trig_time <= timestamp;
            hdr_left <= 2'(`ACQ_HDR_WORDS);
            rec_left <= len_eff;
        end
        else if (state == st_record)
        begin
            if (hdr_left != 2'h0)
                hdr_left <= hdr_left - 2'h1;
            else
            begin
                rec_left <= rec_left - LEN_W'(1);
                if (rec_left == LEN_W'(1))
                    seq <= seq + `ACQ_SEQ_W'(1);
            end
        end
    end

    // -----------------------------------------------------------------------
    // Channel paths
    // -----------------------------------------------------------------------
    for (genvar g = 0; g < `ACQ_LANES; g++)
    begin : g_chan
        chan_path u_chan (
            .clock_i(clock_i),
            .rst_n_i(rst_n),
            .bypass_i(bypass_i[g]),
            .dec_log2_i(dec_log2_i[g*`ACQ_DEC_LOG_W +: `ACQ_DEC_LOG_W]),
            .tune_i(tune_i[g]),
            .tune_load_i(tune_load_i[g]),
            .raw_i(raw_i[g*`ACQ_SAMPLE_W +: `ACQ_SAMPLE_W]),
            .raw_valid_i(raw_valid_i[g]),
            .ddc_i(ddc_i[g*`ACQ_SAMPLE_W +: `ACQ_SAMPLE_W]),
            .ddc_valid_i(ddc_valid_i[g]),
            .sample_o(lane_data[g*`ACQ_SAMPLE_W +: `ACQ_SAMPLE_W]),
            .valid_o(lane_valid[g]),
            .tune_o(tune_o[g])
        );
    end

    // -----------------------------------------------------------------------
    // DRAM FIFO write stream
    // -----------------------------------------------------------------------
    // Header words first, then samples straight through at capture rate
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_valid_o <= 1'b0;
            out_beat_o <= '0;
        end
        else if (state == st_record && hdr_left == `ACQ_HDR_LO_IDX)
        begin
            out_valid_o <= 1'b1;
            out_beat_o <= '{is_header: 1'b1, lane_valid: '0,
                            data: trig_time[31:0]};
        end
        else if (state == st_record && hdr_left == `ACQ_HDR_HI_IDX)
        begin
            out_valid_o <= 1'b1;
            out_beat_o <= '{is_header: 1'b1, lane_valid: '0,
                            data: {seq, trig_time[`ACQ_TS_W-1:32]}};
        end
        else if ((state == st_record || state == st_stream) && lane_valid != '0)
        begin
            out_valid_o <= 1'b1;
            out_beat_o <= '{is_header: 1'b0, lane_valid: lane_valid, data: lane_data};
        end
        else
            out_valid_o <= 1'b0;
    end

    // Acquisition status and lost-beat flag
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acquiring_o <= 1'b0;
            overflow_o <= 1'b0;
        end
        else
        begin
            acquiring_o <= (state == st_record) || (state == st_stream);
            if (out_valid_o && !dram_ready_i)
                overflow_o <= 1'b1;
            else if (state == st_idle && arm_i)
                overflow_o <= 1'b0;
        end
    end

endmodule // acq_ctrl

// file: acq_regs.svh
/*
 * Constants for the acquisition start and record capture block: timing,
 * header layout and stream widths.
 * Assumes a 50 MHz sample-side clock and inclusion by bare name.
 */
`ifndef ACQ_REGS_SVH
`define ACQ_REGS_SVH

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define ACQ_CLK_KHZ 50000
`define ACQ_MAX_REC_MS 200
`define ACQ_MAX_REC_CYCLES (`ACQ_MAX_REC_MS * `ACQ_CLK_KHZ)

// ---------------------------------------------------------------------------
// Stream and header layout
// ---------------------------------------------------------------------------
`define ACQ_SAMPLE_W 16
`define ACQ_LANES 2
`define ACQ_TS_W 48
`define ACQ_SEQ_W 16
`define ACQ_HDR_WORDS 2
`define ACQ_HDR_LO_IDX 2'h2
`define ACQ_HDR_HI_IDX 2'h1
`define ACQ_FREQ_W 32
`define ACQ_BW_W 16
`define ACQ_DEC_LOG_W 4
`define ACQ_DEC_CNT_W 16

`endif

// file: acq_pkg.sv
/*
 * Types shared by the acquisition control block and its channel paths.
 * Assumes acq_regs.svh is on the include path.
 */
`include "acq_regs.svh"

package acq_pkg;

    // -----------------------------------------------------------------------
    // Control states, one-hot
    // -----------------------------------------------------------------------
    typedef enum logic [4:0] {
        st_idle      = 5'h01,
        st_sync_wait = 5'h02,
        st_armed     = 5'h04,
        st_record    = 5'h08,
        st_stream    = 5'h10
    } acq_state_type;

    // -----------------------------------------------------------------------
    // Carriers
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic [`ACQ_FREQ_W-1:0] freq;
        logic [`ACQ_BW_W-1:0] bw;
    } tune_type;

    typedef struct packed {
        logic is_header;
        logic [`ACQ_LANES-1:0] lane_valid;
        logic [`ACQ_LANES*`ACQ_SAMPLE_W-1:0] data;
    } stream_beat_type;

endpackage

// file: chan_path.sv
/*
 * One down-converter output path: bypass select, power-of-two decimation,
 * two-byte sample word and run-time retuning registers.
 * Assumes samples and strobes are synchronous to clock_i and that the
 * mixer and filters sit outside this module.
 */
`include "acq_regs.svh"

module chan_path
    import acq_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Configuration
    input wire logic bypass_i,
    input wire logic [`ACQ_DEC_LOG_W-1:0] dec_log2_i,
    input wire tune_type tune_i,
    input wire logic tune_load_i,
    // Samples
    input wire logic [`ACQ_SAMPLE_W-1:0] raw_i,
    input wire logic raw_valid_i,
    input wire logic [`ACQ_SAMPLE_W-1:0] ddc_i,
    input wire logic ddc_valid_i,
    // Outputs
    output logic [`ACQ_SAMPLE_W-1:0] sample_o,
    output logic valid_o,
    output tune_type tune_o
);

    logic [`ACQ_DEC_CNT_W-1:0] dec_cnt;
    logic [`ACQ_DEC_CNT_W-1:0] dec_mask;

    // -----------------------------------------------------------------------
    // Decimation
    // -----------------------------------------------------------------------
    // Factor is always 2^dec_log2, so a mask on a free counter suffices
    assign dec_mask = (`ACQ_DEC_CNT_W'(1) << dec_log2_i) - `ACQ_DEC_CNT_W'(1);

    // Counts processed samples; restarts when bypassed
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            dec_cnt <= '0;
        else if (bypass_i)
            dec_cnt <= '0;
        else if (ddc_valid_i)
            dec_cnt <= dec_cnt + `ACQ_DEC_CNT_W'(1);
    end

    // Output word: raw in bypass, kept decimated sample otherwise
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sample_o <= '0;
            valid_o <= 1'b0;
        end
        else if (bypass_i)
        begin
            sample_o <= raw_i;
            valid_o <= raw_valid_i;
        end
        else
        begin
            sample_o <= ddc_i;
            valid_o <= ddc_valid_i && ((dec_cnt & dec_mask) == '0);
        end
    end

    // -----------------------------------------------------------------------
    // Retuning
    // -----------------------------------------------------------------------
    // New centre and bandwidth take effect on the next edge, no restart
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tune_o <= '0;
        else if (tune_load_i)
            tune_o <= tune_i;
    end

endmodule // chan_path

// file: acq_ctrl_sva.sv
/*
 * Port checks for acq_ctrl, bound into every instance.
 * Assumes one clock domain and the carriers of acq_pkg.
 */
`include "acq_regs.svh"

module acq_ctrl_sva
    import acq_pkg::*;
#(
    parameter int MAX_RECORD_CYCLES = `ACQ_MAX_REC_CYCLES,
    parameter int LEN_W = 24
)
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Watched inputs
    input wire logic trigger_i,
    input wire logic ref_clk_i,
    input wire logic arm_i,
    input wire logic continuous_i,
    input wire tune_type [`ACQ_LANES-1:0] tune_i,
    input wire logic [`ACQ_LANES-1:0] tune_load_i,
    input wire logic dram_ready_i,
    // Watched outputs
    input wire logic out_valid_o,
    input wire stream_beat_type out_beat_o,
    input wire logic sync_done_o,
    input wire logic acquiring_o,
    input wire logic overflow_o,
    input wire logic nco_lock_o,
    input wire tune_type [`ACQ_LANES-1:0] tune_o
);
    logic trig_d;
    logic ref_d;
    logic [3:0] trig_age;
    logic [3:0] ref_age;
    int acq_cnt;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    // Cycles since the last pin rises, saturating
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            trig_d <= 1'b0;
            ref_d <= 1'b0;
            trig_age <= 4'hf;
            ref_age <= 4'hf;
        end
        else
        begin
            trig_d <= trigger_i;
            ref_d <= ref_clk_i;
            trig_age <= (trigger_i && !trig_d) ? 4'h0 : trig_age + {3'h0, trig_age != 4'hf};
            ref_age <= (ref_clk_i && !ref_d) ? 4'h0 : ref_age + {3'h0, ref_age != 4'hf};
        end
    end

    // Length of the current acquisition
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            acq_cnt <= 0;
        end
        else
        begin
            acq_cnt <= acquiring_o ? acq_cnt + 1 : 0;
        end
    end

    sequence s_hdr_word;
        out_valid_o && out_beat_o.is_header;
    endsequence

    a_start_on_trig: assert property ($rose(acquiring_o) |-> trig_age <= 4'h3)
        else $error("acquisition began without a recent trigger");
    a_gated_sync: assert property ($rose(acquiring_o) |-> $past(sync_done_o))
        else $error("acquisition began before synchronisation");
    a_hdr_first: assert property ($rose(acquiring_o) && !continuous_i |-> ##[0:2] s_hdr_word)
        else $error("record did not open with a header");
    a_hdr_pair: assert property (out_valid_o && out_beat_o.is_header
        && !$past(out_valid_o && out_beat_o.is_header) |=> s_hdr_word)
        else $error("header word missing its second half");
    a_lock_pulse: assert property (nco_lock_o |=> !nco_lock_o)
        else $error("lock pulse longer than one cycle");
    a_lock_on_ref: assert property ($rose(nco_lock_o) |-> ref_age <= 4'h2)
        else $error("lock pulse not tied to a reference edge");
    a_done_at_lock: assert property (nco_lock_o |-> ##[0:1] sync_done_o)
        else $error("sync done not shown at lock");
    a_tune_apply: assert property (tune_load_i[1] |=> tune_o[1] == $past(tune_i[1]))
        else $error("tuning not applied one cycle after load");
    a_overflow_set: assert property (out_valid_o && !dram_ready_i |=> overflow_o)
        else $error("lost beat not flagged");
    a_abort_arm: assert property (!arm_i |-> ##2 !acquiring_o)
        else $error("acquisition outlived disarm");
    a_rec_length: assert property (acquiring_o && !continuous_i
        |-> acq_cnt <= MAX_RECORD_CYCLES + 2)
        else $error("record longer than the limit");
endmodule // acq_ctrl_sva

bind acq_ctrl acq_ctrl_sva #(.MAX_RECORD_CYCLES(MAX_RECORD_CYCLES), .LEN_W(LEN_W)) u_sva (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .trigger_i(trigger_i), .ref_clk_i(ref_clk_i),
    .arm_i(arm_i), .continuous_i(continuous_i), .tune_i(tune_i), .tune_load_i(tune_load_i),
    .dram_ready_i(dram_ready_i), .out_valid_o(out_valid_o), .out_beat_o(out_beat_o),
    .sync_done_o(sync_done_o), .acquiring_o(acquiring_o), .overflow_o(overflow_o),
    .nco_lock_o(nco_lock_o), .tune_o(tune_o)
);

// file: dram_sink.sv
/*
 * Host side of the DRAM FIFO write port: keeps accepted beats in order.
 * Assumes beats are looked at on the falling edge of clock_i.
 */
module dram_sink
    import acq_pkg::*;
(
    // Clock
    input wire logic clock_i,
    // Stall request from the bench
    input wire logic stall_i,
    // Write port
    input wire logic out_valid_i,
    input wire stream_beat_type beat_i,
    output logic dram_ready_o = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;

    stream_beat_type beats[$];

    // Store beats first in, first out, then follow the stall request
    always @(negedge clock_i)
    begin
        if (out_valid_i && dram_ready_o)
        begin
            beats.push_back(beat_i);
        end
        dram_ready_o <= !stall_i;
    end
endmodule // dram_sink

// file: acq_ctrl_tb.sv
/*
 * Self-checking bench for acq_ctrl with the DRAM FIFO host model.
 * Assumes the package, design, checker and sink are compiled first.
 */
`include "acq_regs.svh"

module acq_ctrl_tb
    import acq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MAX_LEN = 64;
    localparam logic [15:0] RAW_WORD = 16'h1234;
    localparam logic [15:0] DDC_WORD = 16'habcd;

    logic clock;
    logic rst_n = 1'b0;
    logic trigger = 1'b0;
    logic align_strobe = 1'b0;
    logic ref_clk = 1'b0;
    logic arm = 1'b0;
    logic continuous = 1'b0;
    logic lock_enable = 1'b0;
    logic [23:0] record_len = 24'h3;
    logic [7:0] dec_log2 = 8'h00;
    logic [1:0] bypass = 2'b01;
    tune_type [1:0] tune = '0;
    logic [1:0] tune_load = 2'b00;
    logic stall = 1'b0;
    logic dram_ready;
    logic out_valid_o, sync_done_o, acquiring_o, overflow_o, nco_lock_o;
    stream_beat_type out_beat_o;
    tune_type [1:0] tune_o;
    int ref_cnt = 0;
    int cycle = 0;
    int mismatches = 0;
    int checks = 0;

    acq_ctrl #(.MAX_RECORD_CYCLES(MAX_LEN), .LEN_W(24)) dut (
        .clock_i(clock), .rst_n_i(rst_n), .trigger_i(trigger), .align_strobe_i(align_strobe),
        .ref_clk_i(ref_clk), .arm_i(arm), .continuous_i(continuous),
        .lock_enable_i(lock_enable), .record_len_i(record_len), .bypass_i(bypass),
        .dec_log2_i(dec_log2), .tune_i(tune), .tune_load_i(tune_load),
        .raw_i({16'h5a5a, RAW_WORD}), .raw_valid_i(2'b11), .ddc_i({DDC_WORD, 16'h0f0f}),
        .ddc_valid_i(2'b11), .dram_ready_i(dram_ready), .out_valid_o(out_valid_o),
        .out_beat_o(out_beat_o), .sync_done_o(sync_done_o), .acquiring_o(acquiring_o),
        .overflow_o(overflow_o), .nco_lock_o(nco_lock_o), .tune_o(tune_o)
    );

    dram_sink sink (.clock_i(clock), .stall_i(stall), .out_valid_i(out_valid_o),
        .beat_i(out_beat_o), .dram_ready_o(dram_ready));

    // --------------------------------------------------------------------
    // Clock, free 10 MHz reference and cycle count
    // --------------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(negedge clock)
    begin
        ref_cnt <= (ref_cnt == 4) ? 0 : ref_cnt + 1;
        ref_clk <= (ref_cnt < 2);
    end

    always @(posedge clock) cycle <= cycle + 1;

    // --------------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------------
    task automatic print_verdict();
        if (mismatches == 0 && checks > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_acq(input logic lvl);
        int n = 0;
        while (acquiring_o !== lvl && n < 300)
        begin
            @(negedge clock);
            n++;
        end
        if (n >= 300)
        begin
            mismatches++;
            print_verdict();
        end
    endtask

    task automatic pulse_trigger(output int at);
        at = cycle;
        trigger = 1'b1;
        repeat (2) @(negedge clock);
        trigger = 1'b0;
    endtask

    // One triggered record, judged by beat count, header words and the last data beat
    task automatic run_record(input logic [23:0] len, input int n_data,
        input logic [15:0] seq, output logic [47:0] ts, output int at);
        stream_beat_type b;
        record_len = len;
        sink.beats.delete();
        pulse_trigger(at);
        wait_acq(1'b1);
        wait_acq(1'b0);
        repeat (3) @(negedge clock);
        check("beat count", sink.beats.size(), n_data + 2);
        b = sink.beats[1];
        check("header flags", {sink.beats[0].is_header, b.is_header}, 2'b11);
        check("sequence", b.data[31:16], seq);
        ts = {b.data[15:0], sink.beats[0].data};
        b = sink.beats[n_data + 1];
        check("data beat", b, {1'b0, 2'b11, DDC_WORD, RAW_WORD});
    endtask

    // --------------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------------
    task automatic sc_records();
        logic [47:0] ts_a, ts_b;
        int at_a, at_b;
        arm = 1'b1;
        repeat (20) @(negedge clock);
        check("idle armed", {acquiring_o, out_valid_o}, 2'b00);
        check("sync done", sync_done_o, 1'b1);
        run_record(24'h3, 3, 16'h0, ts_a, at_a);
        run_record(24'h0, 1, 16'h1, ts_b, at_b);
        check("time stamp step", ts_b - ts_a, 48'(at_b - at_a));
        run_record(24'd100, MAX_LEN, 16'h2, ts_b, at_b);
    endtask

    task automatic sc_lock();
        logic [47:0] ts;
        int at, n;
        arm = 1'b0;
        lock_enable = 1'b1;
        @(negedge clock);
        arm = 1'b1;
        repeat (3) @(negedge clock);
        check("sync pending", sync_done_o, 1'b0);
        sink.beats.delete();
        pulse_trigger(at);
        repeat (12) @(negedge clock);
        check("gated trigger", {acquiring_o, sink.beats.size() == 0}, 2'b01);
        align_strobe = 1'b1;
        repeat (2) @(negedge clock);
        align_strobe = 1'b0;
        n = 0;
        while (nco_lock_o !== 1'b1 && n < 30)
        begin
            @(negedge clock);
            n++;
        end
        check("lock pulse", nco_lock_o, 1'b1);
        check("sync done", sync_done_o, 1'b1);
        repeat (12) @(negedge clock);
        check("no queued start", {acquiring_o, sink.beats.size() == 0}, 2'b01);
        run_record(24'h3, 3, 16'h0, ts, at);
        check("time stamp cleared", ts < 48'd64, 1'b1);
    endtask

    task automatic sc_stream();
        int at;
        int n = 0;
        arm = 1'b0;
        lock_enable = 1'b0;
        continuous = 1'b1;
        dec_log2 = {4'h2, 4'h0};
        @(negedge clock);
        arm = 1'b1;
        @(negedge clock);
        sink.beats.delete();
        pulse_trigger(at);
        wait_acq(1'b1);
        repeat (MAX_LEN + 20) @(negedge clock);
        check("stream runs on", acquiring_o, 1'b1);
        for (int i = 1; i <= 16; i++)
        begin
            n += sink.beats[sink.beats.size() - i].lane_valid[1];
        end
        check("decimated lane rate", n, 4);
        bypass = 2'b10;
        repeat (2) @(negedge clock);
        check("swapped bypass", out_beat_o.data, {16'h5a5a, 16'h0f0f});
        tune[1] = '{freq: 32'h1357_9bdf, bw: 16'h0400};
        tune_load = 2'b10;
        @(negedge clock);
        check("retune", tune_o[1], tune[1]);
        check("retune other lane", tune_o[0], 48'h0);
        tune_load = 2'b00;
        stall <= 1'b1;
        repeat (4) @(negedge clock);
        check("overflow", overflow_o, 1'b1);
        stall <= 1'b0;
        arm = 1'b0;
        repeat (3) @(negedge clock);
        check("stream stopped", acquiring_o, 1'b0);
    endtask

    // --------------------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------------------
    initial
    begin
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        sc_records();
        sc_lock();
        sc_stream();
        print_verdict();
    end

    initial
    begin
        #800000;
        mismatches++;
        print_verdict();
    end
endmodule // acq_ctrl_tb
